// ---- hw/pllsd_top.sv ----
/*
 Serial programming port, reference and main dividers, phase compare and
 switch control of a PLL synthesizer, all on one system clock mclk.
 Assumes serial pins, power save and polarity come asynchronous and are
 synchronised here; oscillator and VCO inputs likewise pass two flops and
 are edge-detected on mclk. Charge pump is modelled as up/down drives.
*/
`timescale 1ns/1ps
module pllsd_top (
   input  wire logic                             mclk,
   input  wire logic                             rst,
   input  wire logic                             serial_clk,
   input  wire logic                             serial_data,
   input  wire logic                             load_strobe,
   input  wire logic                             phase_polarity_select,
   input  wire logic                             power_save_input,
   input  wire logic                             oscillator_input,
   input  wire logic                             vco_input,
   output logic                                  lock_indicator,
   output logic                                  pump_out,
   output logic                                  pump_oe,
   output logic                                  fast_lock_switch_out,
   output logic                                  fast_lock_switch_oe,
   output logic                                  test_monitor_out,
   output logic                                  ref_pulse,
   output logic                                  main_pulse,
   output logic [pllsd_pkg::REF_LATCH_W-1:0]     reference_divider_latch,
   output logic [pllsd_pkg::MAIN_LATCH_W-1:0]    main_divider_latch
);
   import pllsd_pkg::*;

   // Two-flop synchronisers; first stage read only by second
   logic [5:0] sync1, sync2;
   logic       sclk_d;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1  <= 6'h00;
         sync2  <= 6'h00;
         sclk_d <= 1'b0;
      end else begin
         sync1  <= {vco_input, oscillator_input, power_save_input,
                    phase_polarity_select, load_strobe, serial_clk};
         sync2  <= sync1;
         sclk_d <= sync2[0];
      end
   end
   logic s_clk, s_le, s_pol, s_run, s_osc, s_vco;
   assign s_clk = sync2[0];
   assign s_le  = sync2[1];
   assign s_pol = sync2[2];
   assign s_run = sync2[3];
   assign s_osc = sync2[4];
   assign s_vco = sync2[5];
   // Data sampled after same two-flop delay as clock keeps them aligned
   logic d1, d2;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         d1 <= 1'b0;
         d2 <= 1'b0;
      end else begin
         d1 <= serial_data;
         d2 <= d1;
      end
   end
   logic sclk_rise;
   assign sclk_rise = s_clk & ~sclk_d;

   // Shift register and latches
   logic [SHIFT_W-1:0]      shreg, next_shreg;
   logic [REF_LATCH_W-1:0]  next_ref;
   logic [MAIN_LATCH_W-1:0] next_main;
   always_comb begin
      next_shreg = shreg;
      next_ref   = reference_divider_latch;
      next_main  = main_divider_latch;
      if (sclk_rise)
         next_shreg = {shreg[SHIFT_W-2:0], d2};
      if (s_le) begin
         if (shreg[0])
            // Select bit sits just above the count in the latch
            next_ref = {shreg[1], shreg[REF_FRAME_BITS-1:2]};
         else
            next_main = shreg[MAIN_FRAME_BITS-1:1];
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shreg                   <= '0;
         reference_divider_latch <= REF_LATCH_RST;
         main_divider_latch      <= MAIN_LATCH_RST;
      end else begin
         shreg                   <= next_shreg;
         reference_divider_latch <= next_ref;
         main_divider_latch      <= next_main;
      end
   end

   // Field extraction
   logic [REF_CNT_W-1:0] ref_cnt;
   logic [SWAL_W-1:0]    swal_cnt;
   logic [PROG_W-1:0]    prog_cnt;
   assign ref_cnt  = reference_divider_latch[REF_CNT_W-1:0];
   assign swal_cnt = main_divider_latch[SWAL_LSB +: SWAL_W];
   assign prog_cnt = main_divider_latch[PROG_LSB +: PROG_W];

   // Divider counters; standby holds them reset so phases restart aligned
   logic [REF_CNT_W-1:0] rcnt, next_rcnt;
   logic [PROG_W-1:0]    ncnt, next_ncnt;
   logic [SWAL_W-1:0]    acnt, next_acnt;
   logic [7:0]           pcnt, next_pcnt;
   logic                 osc_d, vco_d, next_fr, next_fp;
   logic                 osc_rise, vco_rise, pre_tick;
   assign osc_rise = s_osc & ~osc_d;
   assign vco_rise = s_vco & ~vco_d;
   // Prescaler ratio 129 while swallow count remains, else 128
   assign pre_tick = vco_rise &&
                     (pcnt == ((acnt != 0) ? 8'(PRESCALE_M) : 8'(PRESCALE_M - 1)));
   always_comb begin
      next_rcnt = rcnt;
      next_ncnt = ncnt;
      next_acnt = acnt;
      next_pcnt = pcnt;
      next_fr   = 1'b0;
      next_fp   = 1'b0;
      if (!s_run) begin
         next_rcnt = '0;
         next_ncnt = '0;
         next_acnt = swal_cnt;
         next_pcnt = '0;
      end else begin
         if (osc_rise) begin
            if (rcnt >= ref_cnt - 14'h0001) begin
               next_rcnt = '0;
               next_fr   = 1'b1;
            end else
               next_rcnt = rcnt + 14'h0001;
         end
         if (vco_rise)
            next_pcnt = pre_tick ? 8'h00 : pcnt + 8'h01;
         if (pre_tick) begin
            if (acnt != 0)
               next_acnt = acnt - 7'h01;
            if (ncnt >= prog_cnt - 11'h001) begin
               next_ncnt = '0;
               next_acnt = swal_cnt;
               next_fp   = 1'b1;
            end else
               next_ncnt = ncnt + 11'h001;
         end
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rcnt       <= '0;
         ncnt       <= '0;
         acnt       <= '0;
         pcnt       <= '0;
         osc_d      <= 1'b0;
         vco_d      <= 1'b0;
         ref_pulse  <= 1'b0;
         main_pulse <= 1'b0;
      end else begin
         rcnt       <= next_rcnt;
         ncnt       <= next_ncnt;
         acnt       <= next_acnt;
         pcnt       <= next_pcnt;
         osc_d      <= s_osc;
         vco_d      <= s_vco;
         ref_pulse  <= next_fr;
         main_pulse <= next_fp;
      end
   end

   // Phase comparator: up when reference leads, down when main leads
   logic up, dn, next_up, next_dn;
   logic [3:0] err_len, next_err_len;
   logic next_lock, next_mon;
   always_comb begin
      next_up = up;
      next_dn = dn;
      if (ref_pulse) next_up = 1'b1;
      if (main_pulse) next_dn = 1'b1;
      if (next_up && next_dn) begin
         next_up = 1'b0;
         next_dn = 1'b0;
      end
      next_err_len = (up | dn) ? ((err_len == 4'hF) ? err_len : err_len + 4'h1) : 4'h0;
      // Short error pulses count as locked; standby reports locked
      next_lock = !s_run || (err_len <= 4'(LOCK_WIN));
      next_mon  = s_pol ? ref_pulse : main_pulse;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         up               <= 1'b0;
         dn               <= 1'b0;
         err_len          <= 4'h0;
         lock_indicator   <= 1'b1;
         test_monitor_out <= 1'b0;
      end else begin
         up               <= next_up;
         dn               <= next_dn;
         err_len          <= next_err_len;
         lock_indicator   <= next_lock;
         test_monitor_out <= next_mon;
      end
   end

   // Charge pump: polarity low swaps sense; floats when idle or standby
   assign pump_out            = s_pol ? up : dn;
   assign pump_oe             = s_run & (up ^ dn);
   assign fast_lock_switch_out = pump_out;
   assign fast_lock_switch_oe  = s_le & pump_oe;

   // Assertions
   sequence s_frame_load;
      s_le && !shreg[0];
   endsequence
   property p_main_load;
      @(posedge mclk) disable iff (rst)
      s_frame_load |=> main_divider_latch == $past(shreg[MAIN_FRAME_BITS-1:1]);
   endproperty
   a_main_load: assert property (p_main_load) else $error("main latch not loaded");
   property p_ref_load;
      @(posedge mclk) disable iff (rst)
      s_le && shreg[0] |=>
         reference_divider_latch == {$past(shreg[1]), $past(shreg[REF_FRAME_BITS-1:2])};
   endproperty
   a_ref_load: assert property (p_ref_load) else $error("ref latch not loaded");
   property p_hold;
      @(posedge mclk) disable iff (rst)
      !s_le |=> $stable(main_divider_latch) && $stable(reference_divider_latch);
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed without strobe");
   property p_shift;
      @(posedge mclk) disable iff (rst)
      sclk_rise |=> shreg[0] == $past(d2) && shreg[SHIFT_W-1:1] == $past(shreg[SHIFT_W-2:0]);
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");
   property p_switch_off;
      @(posedge mclk) disable iff (rst) !s_le |-> !fast_lock_switch_oe;
   endproperty
   a_switch_off: assert property (p_switch_off) else $error("switch driven");
   property p_standby;
      @(posedge mclk) disable iff (rst) !s_run |-> !pump_oe ##1 lock_indicator;
   endproperty
   a_standby: assert property (p_standby) else $error("standby wrong");
   property p_monitor;
      @(posedge mclk) disable iff (rst)
      s_pol && ref_pulse |=> test_monitor_out;
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor wrong");
   property p_polarity;
      @(posedge mclk) disable iff (rst)
      up && !dn |-> pump_out == s_pol;
   endproperty
   a_polarity: assert property (p_polarity) else $error("pump sense wrong");
   property p_unlock;
      @(posedge mclk) disable iff (rst)
      s_run && err_len > 4'(LOCK_WIN) && $stable(s_run) |=> !lock_indicator;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock not dropped");
endmodule

// ---- hw/pllsd_pkg.sv ----
/*
 Package for the serial-programmed PLL divider block: field layout of the
 two latches, frame lengths and counter limits.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pllsd_pkg;
   localparam int REF_CNT_W   = 14;   // Reference count width
   localparam int REF_LATCH_W = 15;   // Count plus prescaler select
   localparam int SWAL_W      = 7;    // Swallow count width
   localparam int PROG_W      = 11;   // Programmable count width
   localparam int MAIN_LATCH_W = 18;  // Swallow plus programmable
   localparam int SHIFT_W     = 19;   // Longest frame
   localparam int REF_FRAME_BITS  = 16;
   localparam int MAIN_FRAME_BITS = 19;
   localparam int PRESCALE_M  = 128;  // Dual-modulus base ratio
   localparam int SWAL_LSB    = 0;    // Field position of swallow bits
   localparam int PROG_LSB    = 7;    // Field position of programmable bits
   localparam int PSEL_POS    = 14;   // Prescaler select in reference latch
   localparam logic [REF_LATCH_W-1:0]  REF_LATCH_RST  = 15'h0008;
   localparam logic [MAIN_LATCH_W-1:0] MAIN_LATCH_RST = 18'h00800;
   localparam int LOCK_WIN    = 2;    // Phase error window in cycles
endpackage

// ---- tb/pllsd_host.sv ----
/*
 Host model: shifts frames MSB first into the serial port, then strobes.
 Assumes mclk at 100 ns; serial clock stands still outside frames.
*/
`timescale 1ns/1ps
module pllsd_host (
   input  wire logic mclk,
   output logic      serial_clk,
   output logic      serial_data,
   output logic      load_strobe
);
   // Idle levels
   initial begin
      serial_clk  = 1'h0;
      serial_data = 1'h0;
      load_strobe = 1'h0;
   end
   // Four mclk per half gives the 800 ns serial clock
   task automatic half();
      repeat (4) @(negedge mclk);
   endtask
   // Data moves on the falling serial edge, well past its hold time
   task automatic send(input logic [18:0] bits, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = bits[i];
         half();
         serial_clk = 1'h1;
         half();
         serial_clk = 1'h0;
      end
      serial_data = ~serial_data; // Inverted line shows no stale bit
      half();
      load_strobe = 1'h1;
      half();
      half();
      load_strobe = 1'h0;
   endtask
endmodule

// ---- tb/pllsd_top_tb.sv ----
/*
 Self-checking bench of the PLL divider block with a host model.
 Assumes one signal feeds both oscillator and VCO inputs, so equal ratios lock.
*/
`timescale 1ns/1ps
module pllsd_top_tb;
   import pllsd_pkg::*;
   logic                    mclk, rst, pol, ps, chk_pump, ref_d, main_d;
   logic                    osc = 1'h0;
   logic                    ph  = 1'h0;
   logic                    sclk, sdata, strobe, lock, pump, pump_oe, fl_out, fl_oe;
   logic                    mon, refp, mainp;
   logic [REF_LATCH_W-1:0]  ref_l;
   logic [MAIN_LATCH_W-1:0] main_l;
   int                      failures = 0, n_tests = 0, osc_cnt = 0, hi = 0, lo = 0, mon_cnt = 0;
   int                      lck_cnt = 0;

   pllsd_host u_pllsd_host (.mclk(mclk), .serial_clk(sclk), .serial_data(sdata),
      .load_strobe(strobe));
   pllsd_top u_pllsd_top (.mclk(mclk), .rst(rst), .serial_clk(sclk), .serial_data(sdata),
      .load_strobe(strobe), .phase_polarity_select(pol), .power_save_input(ps),
      .oscillator_input(osc), .vco_input(osc), .lock_indicator(lock), .pump_out(pump),
      .pump_oe(pump_oe), .fast_lock_switch_out(fl_out), .fast_lock_switch_oe(fl_oe),
      .test_monitor_out(mon), .ref_pulse(refp), .main_pulse(mainp),
      .reference_divider_latch(ref_l), .main_divider_latch(main_l));

   // Clock
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Oscillator at 400 ns, counted in the same process to avoid read races
   always @(negedge mclk) begin
      ph <= ~ph;
      if (ph) begin
         osc <= ~osc;
         if (!osc) osc_cnt <= osc_cnt + 1;
      end
      ref_d  <= refp;
      main_d <= mainp;
      hi     <= strobe ? hi + 1 : 0;
      lo     <= strobe ? 0 : lo + 1;
      if (mon === 1'h1) mon_cnt <= mon_cnt + 1;
      // Lock drops only during long error pulses, so count low cycles
      if (lock === 1'h0) lck_cnt <= lck_cnt + 1;
      if (!rst && lo >= 5) chk(fl_oe, 1'h0);
      if (!rst && hi >= 5) chk(fl_oe, pump_oe);
      if (!rst && hi >= 5 && pump_oe === 1'h1) chk(fl_out, pump);
      if (!rst && mon === 1'h1) chk(pol ? (refp | ref_d) : (mainp | main_d), 1'h1);
      if (chk_pump && pump_oe === 1'h1) chk(pump, pol);
   end

   // Waits past the next divider pulse, bounded
   task automatic wait_pulse(input logic which);
      int i;
      i = 0;
      @(negedge mclk);
      while ((which ? refp : mainp) !== 1'h1 && i < 20000) begin
         @(negedge mclk);
         i++;
      end
      if (i >= 20000) chk(1'h0, 1'h1);
      @(negedge mclk);
   endtask

   task automatic gap(input logic which, output int n);
      int s;
      wait_pulse(which);
      s = osc_cnt;
      wait_pulse(which);
      n = osc_cnt - s;
   endtask

   task automatic s_reset();
      chk(ref_l, REF_LATCH_RST);
      chk(main_l, MAIN_LATCH_RST);
      chk(lock, 1'h1);
      chk(pump_oe, 1'h0);
   endtask

   task automatic s_frames();
      u_pllsd_host.send({3'h0, 14'h2A53, 1'h0, 1'h1}, 16);
      chk(ref_l, {1'h0, 14'h2A53});
      chk(main_l, MAIN_LATCH_RST);
      u_pllsd_host.send({11'h5A3, 7'h2C, 1'h0}, 19);
      chk(main_l, {11'h5A3, 7'h2C});
      chk(ref_l, {1'h0, 14'h2A53});
      u_pllsd_host.send({3'h0, 14'h0800, 1'h0, 1'h1}, 16);
      u_pllsd_host.send({11'h010, 7'h00, 1'h0}, 19);
      chk(ref_l, 15'h0800);
      chk(main_l, {11'h010, 7'h00});
   endtask

   // Equal ratios lock; one swallow step unlocks and ref leads
   task automatic s_lock();
      int nr, nm, m, l;
      ps = 1'h1;
      fork
         gap(1'h1, nr);
         gap(1'h0, nm);
      join
      chk(nr, 32'h800);
      chk(nm, 32'h800);
      chk(lock, 1'h1);
      u_pllsd_host.send({11'h010, 7'h01, 1'h0}, 19);
      gap(1'h0, nm);
      chk(nm, 32'h801);
      chk_pump = 1'h1;
      m = mon_cnt;
      wait_pulse(1'h1);
      repeat (4000) @(negedge mclk);
      chk(mon_cnt != m, 1'h1);
      pol = 1'h0;
      m = mon_cnt;
      l = lck_cnt;
      wait_pulse(1'h0);
      repeat (4000) @(negedge mclk);
      chk(mon_cnt != m, 1'h1);
      chk(lck_cnt != l, 1'h1);
      ps = 1'h0;
      repeat (5) @(negedge mclk);
      chk(lock, 1'h1);
      chk(pump_oe, 1'h0);
   endtask

   // Watchdog well above the expected 54k cycles
   initial begin
      repeat (80000) @(negedge mclk);
      failures++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
   end

   // Standby held from power-up; power save always driven
   initial begin
      rst      = 1'h1;
      pol      = 1'h1;
      ps       = 1'h0;
      chk_pump = 1'h0;
      repeat (16) @(negedge mclk);
      rst = 1'h0;
      repeat (4) @(negedge mclk);
      s_reset();
      s_frames();
      s_lock();
      end_sim();
   end
endmodule
